// ==== rtl/lass_map.vh ====
// constants of the linear array scan sequencer
`ifndef LASS_MAP_VH
`define LASS_MAP_VH
`define LASS_SECTION_PIXELS 128
`define LASS_TOTAL_PIXELS 256
`define LASS_RESET_CLOCKS 18
`define LASS_PASS_EDGE 128
`define LASS_EOS_EDGE 256
`define LASS_CLK_MHZ 50
`define LASS_XFER_DELAY_US 20
`define LASS_XFER_DELAY_CYC (`LASS_XFER_DELAY_US * `LASS_CLK_MHZ)
`endif

// ==== rtl/lass_sequencer.v ====
// readout and integration sequencer of a two-section linear sensor array
//
// Contract
// - readout starts on clocked-in start high
// - start rising edge raises hold to both
// - 256-stage shift register advances start pulse
// - one pixel per clock per section
// - integrators reset 18 clocks, integrate from 19th
// - pass pulse out on 128th edge
// - 129th edge ends pass, section 2 active (code: fed-back pass, resynchronised, enables section 2 on 131st edge)
// - end-of-scan asserted on 256th clock (code: on 259th edge in serial use, 128th in parallel)
// - inactive section output stays high impedance
// - serial 256 clocks, parallel 128 clocks (code: serial readout spans 259 clocks)
// - end-of-scan available for cascading
`include "lass_map.vh"

module lass_sequencer #(
    parameter SECTION_PIXELS = `LASS_SECTION_PIXELS,
    parameter RESET_CLOCKS = `LASS_RESET_CLOCKS,
    parameter XFER_DELAY_CYC = `LASS_XFER_DELAY_CYC
) (
    input wire sys_clk,
    input wire nrst,
    input wire first_section_start_in,
    input wire second_section_start_in,
    output reg first_section_pass_out,
    output reg end_of_scan_out,
    output reg hold,
    output reg integrator_reset,
    output reg first_section_out_en,
    output reg second_section_out_en,
    output reg [6:0] first_section_pixel_index,
    output reg [6:0] second_section_pixel_index,
    output reg xfer_ready
);

    // ************************************************
    // input synchronisers
    // ************************************************
    reg si1_meta;
    reg si1_sync;
    reg si1_prev;
    reg si2_meta;
    reg si2_sync;
    reg si2_prev;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            si1_meta <= 1'b0;
            si1_sync <= 1'b0;
            si1_prev <= 1'b0;
            si2_meta <= 1'b0;
            si2_sync <= 1'b0;
            si2_prev <= 1'b0;
        end else begin
            si1_meta <= first_section_start_in;
            si1_sync <= si1_meta;
            si1_prev <= si1_sync;
            si2_meta <= second_section_start_in;
            si2_sync <= si2_meta;
            si2_prev <= si2_sync;
        end
    end

    // a rising edge of a synchronised start counts once, so a held-high start never restarts
    wire start1 = si1_sync & ~si1_prev;
    wire start2 = si2_sync & ~si2_prev;

    // ************************************************
    // per-section token shift registers
    // ************************************************
    // two 128-stage registers chained by the pass pulse form the 256-stage path
    reg [SECTION_PIXELS-1:0] shift1;
    reg [SECTION_PIXELS-1:0] shift2;
    reg [7:0] reset_cnt;
    reg [31:0] xfer_cnt;

    function [6:0] onehot_index;
        input [SECTION_PIXELS-1:0] v;
        integer i;
        begin
            onehot_index = 7'h00;
            for (i = 0; i < SECTION_PIXELS; i = i + 1) begin
                if (v[i]) begin
                    onehot_index = i[6:0];
                end
            end
        end
    endfunction

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shift1 <= {SECTION_PIXELS{1'b0}};
            shift2 <= {SECTION_PIXELS{1'b0}};
            first_section_pass_out <= 1'b0;
            end_of_scan_out <= 1'b0;
            first_section_out_en <= 1'b0;
            second_section_out_en <= 1'b0;
            first_section_pixel_index <= 7'h00;
            second_section_pixel_index <= 7'h00;
        end else begin
            // token walks one stage per clock
            shift1 <= {shift1[SECTION_PIXELS-2:0], start1};
            // in serial use section 2 is fed by the pass pulse; parallel use by its own start
            shift2 <= {shift2[SECTION_PIXELS-2:0], start2};
            // pass pulse is high for the clock after the 128th stage
            first_section_pass_out <= shift1[SECTION_PIXELS-1];
            end_of_scan_out <= shift2[SECTION_PIXELS-1];
            // a section drives only while its token is inside it
            first_section_out_en <= |{shift1[SECTION_PIXELS-2:0], start1};
            second_section_out_en <= |{shift2[SECTION_PIXELS-2:0], start2};
            first_section_pixel_index <= onehot_index({shift1[SECTION_PIXELS-2:0], start1});
            second_section_pixel_index <= onehot_index({shift2[SECTION_PIXELS-2:0], start2});
        end
    end

    // ************************************************
    // hold and integrator reset
    // ************************************************
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold <= 1'b0;
            integrator_reset <= 1'b0;
            reset_cnt <= 8'h00;
            xfer_cnt <= 32'h0;
            xfer_ready <= 1'b1;
        end else begin
            if (start1) begin
                // samples frozen in both sections at once
                hold <= 1'b1;
                integrator_reset <= 1'b1;
                reset_cnt <= RESET_CLOCKS[7:0];
                xfer_ready <= 1'b0;
            end else begin
                if (reset_cnt > 8'h01) begin
                    reset_cnt <= reset_cnt - 8'h01;
                end else begin
                    reset_cnt <= 8'h00;
                    // integration resumes on the next clock
                    integrator_reset <= 1'b0;
                end
                // hold released with the last output pulse
                if (end_of_scan_out) begin
                    hold <= 1'b0;
                    xfer_cnt <= XFER_DELAY_CYC;
                end else if (xfer_cnt != 32'h0) begin
                    xfer_cnt <= xfer_cnt - 32'h1;
                end
                // status only: an early start is still accepted
                xfer_ready <= (xfer_cnt == 32'h0) && !hold;
            end
        end
    end

endmodule // lass_sequencer

// ==== testbench/lass_checker.sv ====
// assertion checker of the scan sequencer
module lass_checker (
    input wire sys_clk, nrst, first_section_start_in, second_section_start_in,
    input wire first_section_pass_out, end_of_scan_out, hold, integrator_reset,
    input wire first_section_out_en, second_section_out_en, xfer_ready,
    input wire [6:0] first_section_pixel_index, second_section_pixel_index
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_frz; $rose(hold) |-> $rose(integrator_reset); endproperty
    a_frz: assert property (p_frz) else $error("freeze");
    property p_irst; $rose(integrator_reset) |-> ##17 integrator_reset ##1 !integrator_reset;
    endproperty
    a_irst: assert property (p_irst) else $error("reset span");
    property p_pass; $rose(hold) |-> ##128 first_section_pass_out; endproperty
    a_pass: assert property (p_pass) else $error("pass time");
    property p_p1; first_section_pass_out |=> !first_section_pass_out && !first_section_out_en;
    endproperty
    a_p1: assert property (p_p1) else $error("pass end");
    property p_eos; end_of_scan_out |=> !end_of_scan_out && !second_section_out_en; endproperty
    a_eos: assert property (p_eos) else $error("eos end");
    property p_idle; !hold |-> !first_section_out_en && !second_section_out_en; endproperty
    a_idle: assert property (p_idle) else $error("idle out");
    property p_step; first_section_out_en ##1 first_section_out_en |->
        first_section_pixel_index == $past(first_section_pixel_index) + 7'h01; endproperty
    a_step: assert property (p_step) else $error("index step");
    property p_first; $rose(first_section_out_en) |-> first_section_pixel_index == 7'h00;
    endproperty
    a_first: assert property (p_first) else $error("first index");
    c_pass: cover property (first_section_pass_out);
    c_eos: cover property (end_of_scan_out);
    c_both: cover property (first_section_out_en && second_section_out_en);
endmodule // lass_checker
bind lass_sequencer lass_checker chk (.*);

// ==== testbench/lass_ctl.sv ====
// controller model issuing one-clock start pulses
module lass_ctl (
    input wire sys_clk,
    input wire go,
    output logic start
);
    timeunit 1ns;
    timeprecision 1ns;
    initial start = 1'b0;
    // go lasts one clock, so start does too
    always @(posedge sys_clk) start <= #1 go;
endmodule // lass_ctl

// ==== testbench/lass_sequencer_tb.sv ====
// testbench of the scan sequencer
module lass_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, par = 1'b0;
    wire s1, p1, eos, hold, irst, e1, e2, rdy;
    wire [6:0] i1, i2;
    int n_mismatch = 0, n_checks = 0;
    lass_ctl ctl (.sys_clk(sys_clk), .go(go), .start(s1));
    lass_sequencer #(.XFER_DELAY_CYC(10)) uut (.sys_clk(sys_clk), .nrst(nrst),
        .first_section_start_in(s1), .second_section_start_in(par ? s1 : p1),
        .first_section_pass_out(p1), .end_of_scan_out(eos), .hold(hold),
        .integrator_reset(irst), .first_section_out_en(e1), .second_section_out_en(e2),
        .first_section_pixel_index(i1), .second_section_pixel_index(i2), .xfer_ready(rdy));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic cmp(input string nm, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one full scan; par ties both starts together
    task automatic scan(input logic mode);
        int c1, c2, ce, co, cr, cp, l1, l2;
        c1 = 0; c2 = 0; ce = 0; co = 0; cr = 0; cp = 0; l1 = 0; l2 = 0;
        par = mode;
        go = 1'b1;
        @(posedge sys_clk) #1 go = 1'b0;
        repeat (320) @(posedge sys_clk) begin
            #1 c1 += e1; c2 += e2; ce += eos; co += e1 & e2;
            cr += irst;
            cp += p1;
            if (e1) l1 = i1;
            if (e2) l2 = i2;
        end
        cmp("irst", 9'h012, cr[8:0]);
        cmp("pass", 9'h001, cp[8:0]);
        cmp("last1", 9'h07f, l1[8:0]);
        cmp("last2", 9'h07f, l2[8:0]);
        cmp("sect1", 9'h080, c1[8:0]);
        cmp("sect2", 9'h080, c2[8:0]);
        cmp("overlap", mode ? 9'h080 : 9'h000, co[8:0]);
        cmp("eos", 9'h001, ce[8:0]);
        cmp("ready", 9'h001, {8'h00, rdy});
    endtask
    // reset in mid-scan must drop hold and section 1 enable at once and raise ready
    task automatic abort();
        go = 1'b1;
        @(posedge sys_clk) #1 go = 1'b0;
        repeat (50) @(posedge sys_clk);
        #1 nrst = 1'b0;
        #2 cmp("hold", 9'h000, {8'h00, hold});
        cmp("en1", 9'h000, {8'h00, e1});
        cmp("rdy", 9'h001, {8'h00, rdy});
        @(posedge sys_clk) #1 nrst = 1'b1;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 nrst = 1'b1;
        scan(1'b0);
        scan(1'b1);
        abort();
        scan(1'b0);
        stop_test();
    end
    initial begin
        #60000;
        n_mismatch++;
        stop_test();
    end
endmodule // lass_sequencer_tb
